// *** logic/psr_host.sv ***
// host end: AXI4-Lite controlled issuer of suspend/resume commands
//
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
module psr_host #(
	parameter int GAP_CYC = psr_pkg::GAP_CYC
) (
	input  wire logic   clk,
	input  wire logic   reset_n,
	psr_link_if.host    link,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp
);

	// ********************************************************
	// state
	// ********************************************************
	logic awHeld, next_awHeld, wHeld, next_wHeld, bvalid, next_bvalid;
	logic rvalid, next_rvalid;
	logic [3:0] awOfs, next_awOfs;
	logic [31:0] wData, next_wData, rdata, next_rdata;
	logic [3:0] wStrb, next_wStrb;
	logic [1:0] bresp, next_bresp, rresp, next_rresp;
	logic [2:0] cmdReg, next_cmdReg;
	logic [31:0] addrReg, next_addrReg, erAddr, next_erAddr, pgAddr, next_pgAddr;
	logic [31:0] descReg, next_descReg;
	logic refused, next_refused, descDone, next_descDone, fetching, next_fetching;
	logic [1:0] fetchIdx, next_fetchIdx;
	logic waitByte, next_waitByte;
	logic [15:0] gapEr, next_gapEr, gapPg, next_gapPg;
	logic cmdValid, next_cmdValid, descReq, next_descReq;
	logic [7:0] cmdOpcode, next_cmdOpcode, descAddr, next_descAddr;
	logic [31:0] cmdAddr, next_cmdAddr;
	logic wrDo, busy;
	logic [31:0] statusWord;

	assign s_axi_awready = !awHeld && !bvalid;
	assign s_axi_wready  = !wHeld && !bvalid;
	assign s_axi_arready = !rvalid;
	assign wrDo = awHeld && wHeld;
	assign busy = link.stErase || link.stProg;
	assign statusWord = {26'h0, descDone, gapEr != 16'h0 || gapPg != 16'h0,
		refused, link.stPgSusp, link.stErSusp, busy};

	// ********************************************************
	// bus slave and command checker
	// ********************************************************
	// a command that breaks a suspend restriction is dropped and flagged
	always_comb begin
		next_awHeld = awHeld;  next_awOfs = awOfs;
		next_wHeld = wHeld;    next_wData = wData;    next_wStrb = wStrb;
		next_bvalid = bvalid && !s_axi_bready;        next_bresp = bresp;
		next_rvalid = rvalid && !s_axi_rready;        next_rdata = rdata;
		next_rresp = rresp;
		next_cmdReg = cmdReg;  next_addrReg = addrReg;
		next_erAddr = erAddr;  next_pgAddr = pgAddr;
		next_refused = refused;
		next_cmdValid = 1'b0;  next_cmdOpcode = cmdOpcode; next_cmdAddr = cmdAddr;
		next_gapEr = gapEr == 16'h0 ? gapEr : gapEr - 16'h1;
		next_gapPg = gapPg == 16'h0 ? gapPg : gapPg - 16'h1;
		next_fetching = fetching; next_fetchIdx = fetchIdx;
		next_waitByte = waitByte; next_descReq = 1'b0;
		next_descAddr = descAddr; next_descReg = descReg; next_descDone = descDone;
		if (s_axi_awvalid && s_axi_awready) begin
			next_awHeld = 1'b1;
			next_awOfs  = s_axi_awaddr[3:0];
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_wHeld = 1'b1;
			next_wData = s_axi_wdata;
			next_wStrb = s_axi_wstrb;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			next_rvalid = 1'b1;
			next_rresp  = psr_pkg::RESP_OKAY;
			unique case (s_axi_araddr[3:0])
				psr_pkg::REG_CMD:    next_rdata = {29'h0, cmdReg};
				psr_pkg::REG_ADDR:   next_rdata = addrReg;
				psr_pkg::REG_STATUS: next_rdata = statusWord;
				psr_pkg::REG_DESC:   next_rdata = descReg;
				default: begin
					next_rdata = 32'h0;
					next_rresp = psr_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (wrDo) begin
			next_awHeld = 1'b0;
			next_wHeld  = 1'b0;
			next_bvalid = 1'b1;
			next_bresp  = psr_pkg::RESP_OKAY;
			if (awOfs == psr_pkg::REG_ADDR) begin
				for (int i = 0; i < 4; i++) begin
					if (wStrb[i]) next_addrReg[8*i +: 8] = wData[8*i +: 8];
				end
			end else if (awOfs == psr_pkg::REG_STATUS) begin
				if (wStrb[0] && wData[psr_pkg::ST_REFUSED_BIT]) next_refused = 1'b0;
			end else if (awOfs == psr_pkg::REG_CMD && wStrb[0]) begin
				next_cmdReg   = wData[2:0];
				next_cmdAddr  = addrReg;
				next_refused  = 1'b1;
				unique case (wData[2:0])
					psr_pkg::CMD_ERASE: if (!busy && !link.stErSusp && !link.stPgSusp) begin
						next_cmdOpcode = psr_pkg::OP_ERASE;
						next_erAddr    = addrReg;
						next_cmdValid  = 1'b1;
					end
					psr_pkg::CMD_PROG: if (!busy && !link.stPgSusp && !(link.stErSusp
						&& addrReg[31:psr_pkg::SECTOR_BITS] == erAddr[31:psr_pkg::SECTOR_BITS])) begin
						next_cmdOpcode = psr_pkg::OP_PROG;
						next_pgAddr    = addrReg;
						next_cmdValid  = 1'b1;
					end
					psr_pkg::CMD_READ: if (!busy && !(link.stErSusp
						&& addrReg[31:psr_pkg::SECTOR_BITS] == erAddr[31:psr_pkg::SECTOR_BITS])
						&& !(link.stPgSusp
						&& addrReg[31:psr_pkg::PAGE_BITS] == pgAddr[31:psr_pkg::PAGE_BITS])) begin
						next_cmdOpcode = psr_pkg::OP_READ;
						next_cmdValid  = 1'b1;
					end
					psr_pkg::CMD_SUSP: begin
						if (link.stErase && gapEr == 16'h0) begin
							next_cmdOpcode = psr_pkg::OP_ER_SUSP;
							next_cmdValid  = 1'b1;
						end else if (link.stProg && !link.stErSusp && gapPg == 16'h0) begin
							next_cmdOpcode = psr_pkg::OP_PG_SUSP;
							next_cmdValid  = 1'b1;
						end
					end
					psr_pkg::CMD_RES: begin
						if (link.stErSusp && !link.stProg) begin
							next_cmdOpcode = psr_pkg::OP_ER_RES;
							next_gapEr     = 16'(GAP_CYC);
							next_cmdValid  = 1'b1;
						end else if (link.stPgSusp) begin
							next_cmdOpcode = psr_pkg::OP_PG_RES;
							next_gapPg     = 16'(GAP_CYC);
							next_cmdValid  = 1'b1;
						end
					end
					psr_pkg::CMD_FETCH: if (!fetching) begin
						next_fetching = 1'b1;
						next_fetchIdx = 2'h0;
						next_descDone = 1'b0;
						next_refused  = refused;
					end
					default: ;
				endcase
				// an accepted command leaves the sticky refusal flag as it was
				if (next_cmdValid) next_refused = refused;
			end else begin
				next_bresp = psr_pkg::RESP_SLVERR;
			end
		end
		// descriptor fetch: four single-byte reads, low byte first
		if (fetching && !waitByte) begin
			next_descReq  = 1'b1;
			next_descAddr = psr_pkg::DESC_OFS | {6'h0, fetchIdx};
			next_waitByte = 1'b1;
		end else if (waitByte && link.descValid) begin
			next_descReg[{fetchIdx, 3'b000} +: 8] = link.descData;
			next_waitByte = 1'b0;
			next_fetchIdx = fetchIdx + 2'h1;
			if (fetchIdx == 2'h3) begin
				next_fetching = 1'b0;
				next_descDone = 1'b1;
			end
		end
	end

	// ********************************************************
	// registers
	// ********************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			awHeld <= 1'b0;  awOfs <= 4'h0;  wHeld <= 1'b0;  wData <= 32'h0;
			wStrb <= 4'h0;   bvalid <= 1'b0; bresp <= 2'h0;  rvalid <= 1'b0;
			rdata <= 32'h0;  rresp <= 2'h0;  cmdReg <= 3'h0; addrReg <= 32'h0;
			erAddr <= 32'h0; pgAddr <= 32'h0; refused <= 1'b0; descReg <= 32'h0;
			descDone <= 1'b0; fetching <= 1'b0; fetchIdx <= 2'h0; waitByte <= 1'b0;
			gapEr <= 16'h0;  gapPg <= 16'h0; cmdValid <= 1'b0; cmdOpcode <= 8'h00;
			cmdAddr <= 32'h0; descReq <= 1'b0; descAddr <= 8'h00;
		end else begin
			awHeld <= next_awHeld;   awOfs <= next_awOfs;     wHeld <= next_wHeld;
			wData <= next_wData;     wStrb <= next_wStrb;     bvalid <= next_bvalid;
			bresp <= next_bresp;     rvalid <= next_rvalid;   rdata <= next_rdata;
			rresp <= next_rresp;     cmdReg <= next_cmdReg;   addrReg <= next_addrReg;
			erAddr <= next_erAddr;   pgAddr <= next_pgAddr;   refused <= next_refused;
			descReg <= next_descReg; descDone <= next_descDone;
			fetching <= next_fetching; fetchIdx <= next_fetchIdx;
			waitByte <= next_waitByte; gapEr <= next_gapEr;   gapPg <= next_gapPg;
			cmdValid <= next_cmdValid; cmdOpcode <= next_cmdOpcode;
			cmdAddr <= next_cmdAddr; descReq <= next_descReq; descAddr <= next_descAddr;
		end
	end

	assign s_axi_bvalid   = bvalid;
	assign s_axi_bresp    = bresp;
	assign s_axi_rvalid   = rvalid;
	assign s_axi_rdata    = rdata;
	assign s_axi_rresp    = rresp;
	assign link.cmdValid  = cmdValid;
	assign link.cmdOpcode = cmdOpcode;
	assign link.cmdAddr   = cmdAddr;
	assign link.descReq   = descReq;
	assign link.descAddr  = descAddr;

endmodule : psr_host

// *** include/psr_pkg.sv ***
// shared constants for the suspend/resume sequencer and its host controller
package psr_pkg;

	// ********************************************************
	// clock and timing
	// ********************************************************
	localparam int CLK_PERIOD_NS = 25;
	localparam int ER_LAT_NS     = 48000;
	localparam int PG_LAT_NS     = 40000;
	localparam int GAP_NS        = 128000;
	// longest times round down, least times round up
	localparam logic [10:0] ER_LAT_CYC = 11'(ER_LAT_NS / CLK_PERIOD_NS);
	localparam logic [10:0] PG_LAT_CYC = 11'(PG_LAT_NS / CLK_PERIOD_NS);
	localparam int          GAP_CYC    = (GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ********************************************************
	// opcodes on the link
	// ********************************************************
	localparam logic [7:0] OP_ER_SUSP = 8'h75;
	localparam logic [7:0] OP_ER_RES  = 8'h7a;
	localparam logic [7:0] OP_PG_SUSP = 8'h85;
	localparam logic [7:0] OP_PG_RES  = 8'h8a;
	localparam logic [7:0] OP_ERASE   = 8'h20;
	localparam logic [7:0] OP_PROG    = 8'h02;
	localparam logic [7:0] OP_READ    = 8'h03;

	// ********************************************************
	// suspend/resume descriptor fields
	// ********************************************************
	localparam logic       D_NOT_SUPP  = 1'b0;     // bit 31
	localparam logic [1:0] D_ER_UNIT   = 2'b10;    // bits 30:29, 8 us
	localparam logic [4:0] D_ER_CNT    = 5'b00101; // bits 28:24
	localparam logic [3:0] D_ER_GAP    = 4'b0001;  // bits 23:20
	localparam logic [1:0] D_PG_UNIT   = 2'b10;    // bits 19:18
	localparam logic [4:0] D_PG_CNT    = 5'b00100; // bits 17:13
	localparam logic [3:0] D_PG_GAP    = 4'b0001;  // bits 12:9
	localparam logic       D_RSVD      = 1'b1;     // bit 8
	localparam logic [3:0] D_ER_FORBID = 4'b1110;  // bits 7:4
	localparam logic [3:0] D_PG_FORBID = 4'b1100;  // bits 3:0
	localparam logic [31:0] DESC_WORD = {D_NOT_SUPP, D_ER_UNIT, D_ER_CNT, D_ER_GAP,
		D_PG_UNIT, D_PG_CNT, D_PG_GAP, D_RSVD, D_ER_FORBID, D_PG_FORBID};
	localparam logic [31:0] OPC_WORD = {OP_ER_SUSP, OP_ER_RES, OP_PG_SUSP, OP_PG_RES};
	localparam logic [7:0]  DESC_OFS = 8'h2c;
	localparam logic [7:0]  OPC_OFS  = 8'h30;
	localparam logic [7:0]  TBL_FILL = 8'hff;

	// ********************************************************
	// host registers and commands
	// ********************************************************
	localparam logic [3:0] REG_CMD    = 4'h0;
	localparam logic [3:0] REG_ADDR   = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_DESC   = 4'hc;
	localparam logic [2:0] CMD_ERASE  = 3'h0;
	localparam logic [2:0] CMD_PROG   = 3'h1;
	localparam logic [2:0] CMD_READ   = 3'h2;
	localparam logic [2:0] CMD_SUSP   = 3'h3;
	localparam logic [2:0] CMD_RES    = 3'h4;
	localparam logic [2:0] CMD_FETCH  = 3'h5;
	localparam int ST_REFUSED_BIT = 3;
	localparam int SECTOR_BITS    = 18;
	localparam int PAGE_BITS      = 9;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage : psr_pkg

// *** include/psr_link_if.sv ***
// link between the host controller and the suspend/resume sequencer
`timescale 1ns/1ps
interface psr_link_if;
	logic        cmdValid;
	logic [7:0]  cmdOpcode;
	logic [31:0] cmdAddr;
	logic        descReq;
	logic [7:0]  descAddr;
	logic        descValid;
	logic [7:0]  descData;
	logic        stErase;
	logic        stProg;
	logic        stErSusp;
	logic        stPgSusp;

	modport device (
		input  cmdValid, cmdOpcode, cmdAddr, descReq, descAddr,
		output descValid, descData, stErase, stProg, stErSusp, stPgSusp
	);
	modport host (
		output cmdValid, cmdOpcode, cmdAddr, descReq, descAddr,
		input  descValid, descData, stErase, stProg, stErSusp, stPgSusp
	);
endinterface : psr_link_if

// *** logic/psr_device.sv ***
// device end: program/erase suspend and resume sequencer with its table
`timescale 1ns/1ps
module psr_device (
	input  wire logic  clk,
	input  wire logic  reset_n,
	psr_link_if.device link,
	output logic        arrayStart,
	output logic        arrayErase,
	output logic [31:0] arrayAddr,
	output logic        arrayHalt,
	output logic        arrayResume,
	input  wire logic   arrayHalted,
	input  wire logic   arrayDone
);

	// ********************************************************
	// state
	// ********************************************************
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ERASE,
		ST_ER_STOP,
		ST_ER_SUSP,
		ST_NEST_PROG,
		ST_PROG,
		ST_PG_STOP,
		ST_PG_SUSP
	} psr_dstate_e;

	psr_dstate_e state;
	psr_dstate_e next_state;
	logic [10:0] latCnt;
	logic [10:0] next_latCnt;
	logic        next_arrayStart;
	logic        next_arrayErase;
	logic [31:0] next_arrayAddr;
	logic        next_arrayHalt;
	logic        next_arrayResume;
	logic        stErase;
	logic        stProg;
	logic        stErSusp;
	logic        stPgSusp;
	logic        next_stErase;
	logic        next_stProg;
	logic        next_stErSusp;
	logic        next_stPgSusp;
	logic        descValid;
	logic [7:0]  descData;
	logic        next_descValid;
	logic [7:0]  next_descData;

	// ********************************************************
	// opcode decode
	// ********************************************************
	// one-cycle command strobes; anything else on the link is ignored
	logic opErase;
	logic opProg;
	logic opErSusp;
	logic opErRes;
	logic opPgSusp;
	logic opPgRes;
	assign opErase  = link.cmdValid && link.cmdOpcode == psr_pkg::OP_ERASE;
	assign opProg   = link.cmdValid && link.cmdOpcode == psr_pkg::OP_PROG;
	assign opErSusp = link.cmdValid && link.cmdOpcode == psr_pkg::OP_ER_SUSP;
	assign opErRes  = link.cmdValid && link.cmdOpcode == psr_pkg::OP_ER_RES;
	assign opPgSusp = link.cmdValid && link.cmdOpcode == psr_pkg::OP_PG_SUSP;
	assign opPgRes  = link.cmdValid && link.cmdOpcode == psr_pkg::OP_PG_RES;

	// ********************************************************
	// sequencer next state
	// ********************************************************
	// a halt ends on the array's acknowledge or at the latency bound,
	// whichever comes first, so the bound holds even for a slow array
	always_comb begin
		next_state       = state;
		next_latCnt      = latCnt;
		next_arrayStart  = 1'b0;
		next_arrayResume = 1'b0;
		next_arrayErase  = arrayErase;
		next_arrayAddr   = arrayAddr;
		unique case (state)
			ST_IDLE: begin
				if (opErase) begin
					next_state      = ST_ERASE;
					next_arrayStart = 1'b1;
					next_arrayErase = 1'b1;
					next_arrayAddr  = link.cmdAddr;
				end else if (opProg) begin
					next_state      = ST_PROG;
					next_arrayStart = 1'b1;
					next_arrayErase = 1'b0;
					next_arrayAddr  = link.cmdAddr;
				end
			end
			ST_ERASE: begin
				if (arrayDone) begin
					next_state = ST_IDLE;
				end else if (opErSusp) begin
					next_state  = ST_ER_STOP;
					next_latCnt = psr_pkg::ER_LAT_CYC - 11'h001;
				end
			end
			ST_ER_STOP: begin
				// the erase may still finish before it halts
				if (arrayDone) begin
					next_state = ST_IDLE;
				end else if (arrayHalted || latCnt == 11'h000) begin
					next_state = ST_ER_SUSP;
				end else begin
					next_latCnt = latCnt - 11'h001;
				end
			end
			ST_ER_SUSP: begin
				if (opErRes) begin
					next_state       = ST_ERASE;
					next_arrayResume = 1'b1;
					next_arrayErase  = 1'b1;
				end else if (opProg) begin
					// program outside the suspended sector; the host keeps it out
					next_state      = ST_NEST_PROG;
					next_arrayStart = 1'b1;
					next_arrayErase = 1'b0;
					next_arrayAddr  = link.cmdAddr;
				end
			end
			ST_NEST_PROG: begin
				// a program nested in an erase suspend cannot itself be suspended
				if (arrayDone) begin
					next_state = ST_ER_SUSP;
				end
			end
			ST_PROG: begin
				if (arrayDone) begin
					next_state = ST_IDLE;
				end else if (opPgSusp) begin
					next_state  = ST_PG_STOP;
					next_latCnt = psr_pkg::PG_LAT_CYC - 11'h001;
				end
			end
			ST_PG_STOP: begin
				if (arrayDone) begin
					next_state = ST_IDLE;
				end else if (arrayHalted || latCnt == 11'h000) begin
					next_state = ST_PG_SUSP;
				end else begin
					next_latCnt = latCnt - 11'h001;
				end
			end
			ST_PG_SUSP: begin
				if (opPgRes) begin
					next_state       = ST_PROG;
					next_arrayResume = 1'b1;
					next_arrayErase  = 1'b0;
				end
			end
		endcase
	end

	// ********************************************************
	// status decode from the next state
	// ********************************************************
	// decoded ahead so that the flopped status lines up with the state
	always_comb begin
		next_arrayHalt = next_state == ST_ER_STOP || next_state == ST_PG_STOP;
		next_stErase   = next_state == ST_ERASE || next_state == ST_ER_STOP;
		next_stProg    = next_state == ST_PROG || next_state == ST_PG_STOP
			|| next_state == ST_NEST_PROG;
		next_stErSusp  = next_state == ST_ER_SUSP || next_state == ST_NEST_PROG;
		next_stPgSusp  = next_state == ST_PG_SUSP;
	end

	// ********************************************************
	// parameter table read
	// ********************************************************
	// one byte per request, answered on the next cycle, low byte first
	always_comb begin
		next_descValid = link.descReq;
		next_descData  = descData;
		if (link.descReq) begin
			if (link.descAddr[7:2] == psr_pkg::DESC_OFS[7:2]) begin
				next_descData = psr_pkg::DESC_WORD[{link.descAddr[1:0], 3'b000} +: 8];
			end else if (link.descAddr[7:2] == psr_pkg::OPC_OFS[7:2]) begin
				next_descData = psr_pkg::OPC_WORD[{link.descAddr[1:0], 3'b000} +: 8];
			end else begin
				next_descData = psr_pkg::TBL_FILL;
			end
		end
	end

	// ********************************************************
	// registers
	// ********************************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state       <= ST_IDLE;
			latCnt      <= 11'h000;
			arrayStart  <= 1'b0;
			arrayErase  <= 1'b0;
			arrayAddr   <= 32'h0000_0000;
			arrayHalt   <= 1'b0;
			arrayResume <= 1'b0;
			stErase     <= 1'b0;
			stProg      <= 1'b0;
			stErSusp    <= 1'b0;
			stPgSusp    <= 1'b0;
			descValid   <= 1'b0;
			descData    <= 8'h00;
		end else begin
			state       <= next_state;
			latCnt      <= next_latCnt;
			arrayStart  <= next_arrayStart;
			arrayErase  <= next_arrayErase;
			arrayAddr   <= next_arrayAddr;
			arrayHalt   <= next_arrayHalt;
			arrayResume <= next_arrayResume;
			stErase     <= next_stErase;
			stProg      <= next_stProg;
			stErSusp    <= next_stErSusp;
			stPgSusp    <= next_stPgSusp;
			descValid   <= next_descValid;
			descData    <= next_descData;
		end
	end

	// ********************************************************
	// link outputs
	// ********************************************************
	assign link.descValid = descValid;
	assign link.descData  = descData;
	assign link.stErase   = stErase;
	assign link.stProg    = stProg;
	assign link.stErSusp  = stErSusp;
	assign link.stPgSusp  = stPgSusp;

endmodule : psr_device

// *** verif/psr_asserts.sv ***
// checker on the link between host controller and suspend/resume sequencer
`timescale 1ns/1ps
module psr_asserts #(
	parameter int GAP_CYC = psr_pkg::GAP_CYC
) (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        cmdValid,
	input wire logic [7:0]  cmdOpcode,
	input wire logic [31:0] cmdAddr,
	input wire logic        descReq,
	input wire logic [7:0]  descAddr,
	input wire logic        descValid,
	input wire logic [7:0]  descData,
	input wire logic        stErase,
	input wire logic        stProg,
	input wire logic        stErSusp,
	input wire logic        stPgSusp
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic        halting;
	logic        haltPg;
	logic [10:0] haltCnt;
	int          gapEr;
	int          gapPg;
	logic [31:0] erAddr;
	// halt timer, resume gap timers and the sector of the last erase
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{halting, haltPg, haltCnt, gapEr, gapPg, erAddr} <= '0;
		end else begin
			if (cmdValid && cmdOpcode == 8'h75 && stErase) begin
				{halting, haltPg, haltCnt} <= {2'b10, 11'h0};
			end else if (cmdValid && cmdOpcode == 8'h85 && stProg && !stErSusp) begin
				{halting, haltPg, haltCnt} <= {2'b11, 11'h0};
			end else if (stErSusp || stPgSusp || !(stErase || stProg)) begin
				halting <= 1'b0;
			end else if (halting) begin
				haltCnt <= haltCnt + 11'h1;
			end
			// loaded one short so that zero marks the first legal suspend edge
			gapEr <= (cmdValid && cmdOpcode == 8'h7a) ? GAP_CYC - 1 : (gapEr > 0 ? gapEr - 1 : 0);
			gapPg <= (cmdValid && cmdOpcode == 8'h8a) ? GAP_CYC - 1 : (gapPg > 0 ? gapPg - 1 : 0);
			if (cmdValid && cmdOpcode == psr_pkg::OP_ERASE) erAddr <= cmdAddr;
		end
	end
	sequence s_erRes; cmdValid && cmdOpcode == 8'h7a && stErSusp && !stProg; endsequence
	sequence s_pgRes; cmdValid && cmdOpcode == 8'h8a && stPgSusp; endsequence
	property p_er_res; s_erRes |=> stErase && !stErSusp; endproperty
	property p_pg_res; s_pgRes |=> stProg && !stPgSusp; endproperty
	property p_desc; descReq && descAddr == 8'h2c |=> descValid && descData == 8'hec; endproperty
	// one cycle of slack: the bound is counted from the edge after the take
	property p_lat; halting |-> haltCnt <= (haltPg ? 11'd1600 : 11'd1920); endproperty
	property p_er_gap; cmdValid && cmdOpcode == 8'h75 |-> gapEr == 0; endproperty
	property p_pg_gap; cmdValid && cmdOpcode == 8'h85 |-> gapPg == 0; endproperty
	property p_er_forbid;
		stErSusp && cmdValid |-> cmdOpcode != psr_pkg::OP_ERASE && !((cmdOpcode ==
			psr_pkg::OP_PROG || cmdOpcode == psr_pkg::OP_READ) && cmdAddr[31:18] == erAddr[31:18]);
	endproperty
	property p_pg_forbid;
		stPgSusp && cmdValid |-> cmdOpcode != psr_pkg::OP_ERASE && cmdOpcode != psr_pkg::OP_PROG;
	endproperty
	a_er_res: assert property (p_er_res) else $error("erase resume not taken");
	a_pg_res: assert property (p_pg_res) else $error("program resume not taken");
	a_desc: assert property (p_desc) else $error("descriptor byte wrong");
	a_lat: assert property (p_lat) else $error("suspend latency exceeded");
	a_er_gap: assert property (p_er_gap) else $error("erase suspend too soon");
	a_pg_gap: assert property (p_pg_gap) else $error("program suspend too soon");
	a_er_forbid: assert property (p_er_forbid) else $error("illegal op in erase suspend");
	a_pg_forbid: assert property (p_pg_forbid) else $error("illegal op in prog suspend");
endmodule : psr_asserts

// *** verif/tb_program_erase_suspend_resume.sv ***
// testbench joining host controller and sequencer over the link
`timescale 1ns/1ps
module tb_program_erase_suspend_resume;
	logic        clk, reset_n, halted, done, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, ta, tw, tr, hlt;
	logic [31:0] awaddr, wdata, araddr, rdata, st, aad;
	logic [1:0]  bresp, rresp, resp;
	int          errors, comparisons;
	psr_link_if lnk ();
	psr_device psr_device_inst (.clk(clk), .reset_n(reset_n), .link(lnk), .arrayStart(),
		.arrayErase(), .arrayAddr(aad), .arrayHalt(hlt), .arrayResume(), .arrayHalted(halted),
		.arrayDone(done));
	psr_host #(.GAP_CYC(20)) psr_host_inst (.clk(clk), .reset_n(reset_n), .link(lnk),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
	psr_asserts #(.GAP_CYC(20)) psr_asserts_inst (.clk(clk), .reset_n(reset_n),
		.cmdValid(lnk.cmdValid), .cmdOpcode(lnk.cmdOpcode), .cmdAddr(lnk.cmdAddr),
		.descReq(lnk.descReq), .descAddr(lnk.descAddr), .descValid(lnk.descValid),
		.descData(lnk.descData), .stErase(lnk.stErase), .stProg(lnk.stProg),
		.stErSusp(lnk.stErSusp), .stPgSusp(lnk.stPgSusp));
	// ****
	// helpers
	// ****
	task complete_run();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task hang();
		errors++;
		complete_run();
	endtask : hang
	// ready is sampled at the falling edge, where it is settled for the next rise
	task axw(input logic [31:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		{awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			{ta, tw, tr, resp} = {awvalid & awready, wvalid & wready, bvalid & bready, bresp};
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			if (tr) break;
		end
		bready <= 1'b0;
		if (i == 40) hang();
	endtask : axw
	task axr(input logic [31:0] a);
		int i;
		@(posedge clk);
		{araddr, arvalid, rready} <= {a, 2'b11};
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			{ta, tr, st, resp} = {arvalid & arready, rvalid & rready, rdata, rresp};
			@(posedge clk);
			if (ta) arvalid <= 1'b0;
			if (tr) break;
		end
		rready <= 1'b0;
		if (i == 40) hang();
	endtask : axr
	// command, then check and clear the sticky refusal flag
	task issue(input logic [31:0] a, input logic [2:0] c, input logic expRef);
		axw(32'h4, a);
		axw(32'h0, {29'h0, c});
		repeat (4) @(posedge clk);
		axr(32'h8);
		chk(32'(st[3]), 32'(expRef));
		axw(32'h8, 32'h8);
	endtask : issue
	task waitSt(input logic [31:0] m);
		int i;
		for (i = 0; i < 800; i++) begin
			axr(32'h8);
			if ((st & m) === m) break;
		end
		if (i == 800) hang();
		chk(st & m, m);
	endtask : waitSt
	// one-cycle pulse from the array: halted when h is set, else done
	task strobe(input logic h);
		@(posedge clk);
		{halted, done} <= {h, !h};
		@(posedge clk);
		{halted, done} <= 2'b00;
	endtask : strobe
	// ****
	// scenarios
	// ****
	task t_desc();
		issue(32'h0, psr_pkg::CMD_FETCH, 1'b0);
		waitSt(32'h20);
		axr(32'hc);
		chk(st, 32'h4518_83ec);
		chk(32'(st[31]), 32'h0);
		chk(32'(st[8]), 32'h1);
		axr(32'h6);
		chk(32'(resp), 32'(psr_pkg::RESP_SLVERR));
	endtask : t_desc
	task t_erase();
		issue(32'h0004_0000, psr_pkg::CMD_ERASE, 1'b0);
		issue(32'h0, psr_pkg::CMD_SUSP, 1'b0);
		chk(32'(hlt), 32'h1);
		strobe(1'b1);
		waitSt(32'h2);
		issue(32'h0008_0000, psr_pkg::CMD_ERASE, 1'b1);
		issue(32'h0004_0200, psr_pkg::CMD_PROG, 1'b1);
		issue(32'h0007_fff0, psr_pkg::CMD_READ, 1'b1);
		issue(32'h0008_0000, psr_pkg::CMD_PROG, 1'b0);
		chk(aad, 32'h0008_0000);
		strobe(1'b0);
		issue(32'h0, psr_pkg::CMD_RES, 1'b0);
		issue(32'h0, psr_pkg::CMD_SUSP, 1'b1);
		repeat (25) @(posedge clk);
		issue(32'h0, psr_pkg::CMD_SUSP, 1'b0);
		waitSt(32'h2);
		issue(32'h0, psr_pkg::CMD_RES, 1'b0);
		strobe(1'b0);
		axr(32'h8);
		chk(st & 32'h7, 32'h0);
	endtask : t_erase
	task t_prog();
		issue(32'h0000_1200, psr_pkg::CMD_PROG, 1'b0);
		issue(32'h0, psr_pkg::CMD_SUSP, 1'b0);
		chk(32'(hlt), 32'h1);
		strobe(1'b1);
		waitSt(32'h4);
		issue(32'h0010_0000, psr_pkg::CMD_ERASE, 1'b1);
		issue(32'h0010_0000, psr_pkg::CMD_PROG, 1'b1);
		issue(32'h0000_13ff, psr_pkg::CMD_READ, 1'b1);
		issue(32'h0000_1400, psr_pkg::CMD_READ, 1'b0);
		issue(32'h0, psr_pkg::CMD_RES, 1'b0);
		issue(32'h0, psr_pkg::CMD_SUSP, 1'b1);
		repeat (25) @(posedge clk);
		issue(32'h0, psr_pkg::CMD_SUSP, 1'b0);
		waitSt(32'h4);
		issue(32'h0, psr_pkg::CMD_RES, 1'b0);
		strobe(1'b0);
		axr(32'h8);
		chk(st & 32'h7, 32'h0);
	endtask : t_prog
	// clock and main sequence
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		{reset_n, halted, done, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, wdata, araddr} = '0;
		repeat (4) @(posedge clk);
		reset_n <= 1'b1;
		t_desc();
		t_erase();
		t_prog();
		complete_run();
	end
endmodule : tb_program_erase_suspend_resume
